// >>> inc/serial_channel_pkg.sv
// Purpose: shared constants and types for one serial channel register slice
// Assumes: 8-bit parallel processor port, one system clock
// Notes: pointer values select the indexed registers through the command register
package serial_channel_pkg;

	localparam int DATA_W = 8;
	localparam int PTR_W = 3;

	// register pointer values
	localparam logic [PTR_W-1:0] PTR_STATUS = 3'h0;
	localparam logic [PTR_W-1:0] PTR_SPECIAL = 3'h1;
	localparam logic [PTR_W-1:0] PTR_VECTOR = 3'h2;
	localparam logic [PTR_W-1:0] PTR_TX_CONTROL = 3'h5;
	localparam logic [PTR_W-1:0] PTR_TX_SYNC = 3'h6;
	localparam logic [PTR_W-1:0] PTR_RX_SYNC = 3'h7;

	// command register fields
	localparam int CMD_PTR_LSB = 0;
	localparam int CMD_CODE_LSB = 3;
	localparam int CMD_CRC_LSB = 6;
	localparam logic [2:0] CMD_RESET_EXT = 3'h2;
	localparam logic [2:0] CMD_CHANNEL_RESET = 3'h3;
	localparam logic [1:0] CMD_RESET_UNDERRUN = 2'h3;

	// transmit_control fields
	localparam int TXC_TX_ENABLE = 3;
	localparam int TXC_LEN_LSB = 5;
	localparam int TXC_READY = 7;

	// character length codes
	localparam logic [1:0] LEN_FIVE_OR_LESS = 2'h0;
	localparam logic [1:0] LEN_SEVEN = 2'h1;
	localparam logic [1:0] LEN_SIX = 2'h2;
	localparam logic [1:0] LEN_EIGHT = 2'h3;
	localparam int FIVE_MAX_BITS = 5;

	// reset values and global address
	localparam logic [DATA_W-1:0] TX_CONTROL_RESET = 8'h00;
	localparam logic [DATA_W-1:0] TX_SYNC_RESET = 8'h00;
	localparam logic [DATA_W-1:0] RX_SYNC_RESET = 8'h00;
	localparam logic [DATA_W-1:0] GLOBAL_ADDRESS = 8'hFF;
	localparam logic [DATA_W-1:0] VECTOR_RESET = 8'h00;

	// status bit positions
	localparam int ST_RX_AVAIL = 0;
	localparam int ST_INT_PENDING = 1;
	localparam int ST_TX_EMPTY = 2;
	localparam int ST_CARRIER = 3;
	localparam int ST_SYNC_HUNT = 4;
	localparam int ST_CLEAR_TO_SEND = 5;
	localparam int ST_UNDERRUN = 6;
	localparam int ST_BREAK = 7;

	// link timing: transmit clock period in the bench, system clock period
	localparam int TX_CLK_PERIOD_NS = 160;
	localparam int SYS_CLK_PERIOD_NS = 10;
	localparam int TX_CLK_HALF_CYCLES = TX_CLK_PERIOD_NS / (2 * SYS_CLK_PERIOD_NS);

	// latched external/status sources
	typedef struct packed {
		logic break_abort;
		logic underrun;
		logic cts;
		logic sync_hunt;
		logic carrier;
	} ext_status_t;

	// snapshot after reset: underrun set, carrier pin idle high
	localparam ext_status_t EXT_STATUS_RESET = 5'h09;

	// processor access strobes
	typedef struct packed {
		logic sel;
		logic cmd;
		logic wr;
		logic rd;
		logic [DATA_W-1:0] wdata;
	} bus_req_t;

endpackage

// >>> rtl/pin_sync.sv
// Purpose: two-stage synchroniser for pin inputs
// Assumes: inputs are asynchronous levels
// Notes: only the second stage may be read by logic
`timescale 1ns/1ps
module pin_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] stage1;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stage1 <= INIT;
			sync_out <= INIT;
		end else begin
			stage1 <= async_in;
			sync_out <= stage1;
		end
	end

endmodule

// >>> rtl/serial_channel_sync_regs_status.sv
// Purpose: per-channel transmit control, sync/address registers and first status register
// Assumes: processor strobes are one-cycle pulses on ref_clk; modem pins and tx clock are asynchronous
// Notes: pointer written through the command register selects the next command-port access, then returns to zero
`timescale 1ns/1ps
module serial_channel_sync_regs_status
	import serial_channel_pkg::*;
#(
	parameter bit FIRST_CHANNEL = 1'b1
) (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire bus_req_t bus_req,
	output logic [DATA_W-1:0] bus_rdata,
	input wire logic tx_clk,
	output logic txd,
	output logic terminal_ready_n,
	input wire logic carrier_detect_n,
	input wire logic clear_to_send_n,
	input wire logic sync_n,
	input wire logic rx_char_avail,
	input wire logic break_abort,
	input wire logic crc_sending,
	input wire logic sync_mode,
	input wire logic [DATA_W-1:0] rx_address,
	output logic address_match,
	output logic [DATA_W-1:0] tx_sync_char,
	output logic [DATA_W-1:0] rx_sync_char,
	input wire logic other_channel_irq,
	output logic channel_irq,
	output logic int_pending
);

	typedef enum {TX_IDLE, TX_SHIFT} tx_state_t;

	// leading ones form the marker prefix; fewer ones means more data bits
	function automatic logic [3:0] five_or_less_bits(input logic [DATA_W-1:0] ch);
		logic [3:0] ones;
		logic stop;
		ones = 4'h0;
		stop = 1'b0;
		for (int i = DATA_W - 1; i >= DATA_W - 4; i--) begin
			if (!stop && ch[i]) begin
				ones = ones + 4'h1;
			end else begin
				stop = 1'b1;
			end
		end
		return 4'(FIVE_MAX_BITS) - ones;
	endfunction

	function automatic logic [3:0] char_bits(input logic [1:0] code, input logic [DATA_W-1:0] ch);
		case (code)
			LEN_SEVEN: return 4'h7;
			LEN_SIX: return 4'h6;
			LEN_EIGHT: return 4'h8;
			default: return five_or_less_bits(ch);
		endcase
	endfunction

	logic [DATA_W-1:0] transmit_control;
	logic [DATA_W-1:0] transmit_sync_or_address;
	logic [DATA_W-1:0] receive_sync_or_flag;
	logic [PTR_W-1:0] reg_pointer;
	logic [DATA_W-1:0] tx_buffer;
	logic tx_buffer_empty;
	logic [DATA_W-1:0] tx_shift;
	logic [3:0] tx_bits_left;
	tx_state_t tx_state;
	logic tx_clk_s;
	logic tx_clk_prev;
	logic tx_fall;
	logic carrier_s;
	logic cts_s;
	logic sync_s;
	ext_status_t live;
	ext_status_t live_prev;
	ext_status_t latched;
	logic ext_pending;
	logic underrun_latch;
	logic underrun_set;
	logic [DATA_W-1:0] status_byte;

	logic cmd_write;
	logic data_write;
	logic cmd_read;
	logic is_command;
	logic ext_reset_cmd;
	logic channel_reset;
	logic underrun_reset_cmd;
	logic load_buffer;
	logic take_buffer;

	pin_sync #(.WIDTH(4), .INIT(4'hF)) u_pin_sync (
		.clk(ref_clk),
		.rst_n(arst_n),
		.async_in({tx_clk, carrier_detect_n, clear_to_send_n, sync_n}),
		.sync_out({tx_clk_s, carrier_s, cts_s, sync_s})
	);

	// bus decode
	assign cmd_write = bus_req.sel && bus_req.cmd && bus_req.wr;
	assign data_write = bus_req.sel && !bus_req.cmd && bus_req.wr;
	assign cmd_read = bus_req.sel && bus_req.cmd && bus_req.rd;
	assign is_command = cmd_write && (reg_pointer == PTR_STATUS);
	assign ext_reset_cmd = is_command && (bus_req.wdata[CMD_CODE_LSB +: 3] == CMD_RESET_EXT);
	assign channel_reset = is_command && (bus_req.wdata[CMD_CODE_LSB +: 3] == CMD_CHANNEL_RESET);
	assign underrun_reset_cmd = is_command && (bus_req.wdata[CMD_CRC_LSB +: 2] == CMD_RESET_UNDERRUN);

	// pointer: set by command write, cleared after the next command-port access
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			reg_pointer <= PTR_STATUS;
		end else if (is_command) begin
			reg_pointer <= bus_req.wdata[CMD_PTR_LSB +: PTR_W];
		end else if (cmd_write || cmd_read) begin
			reg_pointer <= PTR_STATUS;
		end
	end

	// write-only control and sync registers; status pointer writes are commands
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			transmit_control <= TX_CONTROL_RESET;
			transmit_sync_or_address <= TX_SYNC_RESET;
			receive_sync_or_flag <= RX_SYNC_RESET;
		end else if (channel_reset) begin
			transmit_control <= TX_CONTROL_RESET;
		end else if (cmd_write) begin
			case (reg_pointer)
				PTR_TX_CONTROL: transmit_control <= bus_req.wdata;
				PTR_TX_SYNC: transmit_sync_or_address <= bus_req.wdata;
				PTR_RX_SYNC: receive_sync_or_flag <= bus_req.wdata;
				default: ;
			endcase
		end
	end

	assign terminal_ready_n = ~transmit_control[TXC_READY];
	assign tx_sync_char = transmit_sync_or_address;
	assign rx_sync_char = receive_sync_or_flag;

	// secondary address or global address accepted
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			address_match <= 1'b0;
		end else begin
			address_match <= (rx_address == transmit_sync_or_address) || (rx_address == GLOBAL_ADDRESS);
		end
	end

	// transmit clock edge detection on the synchronised level
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			tx_clk_prev <= 1'b1;
		end else begin
			tx_clk_prev <= tx_clk_s;
		end
	end
	assign tx_fall = tx_clk_prev && !tx_clk_s;

	assign load_buffer = data_write;
	assign take_buffer = tx_fall && !tx_buffer_empty && transmit_control[TXC_TX_ENABLE] &&
		(tx_state == TX_IDLE || tx_bits_left == 4'h1);

	// transmit buffer and its empty flag
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			tx_buffer <= 8'h00;
			tx_buffer_empty <= 1'b1;
		end else if (channel_reset) begin
			tx_buffer_empty <= 1'b1;
		end else if (load_buffer) begin
			tx_buffer <= bus_req.wdata;
			tx_buffer_empty <= 1'b0;
		end else if (take_buffer && !(sync_mode && crc_sending)) begin
			tx_buffer_empty <= 1'b1;
		end
	end

	// shifter: lsb first, length from the control field
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			tx_state <= TX_IDLE;
			tx_shift <= 8'h00;
			tx_bits_left <= 4'h0;
			txd <= 1'b1;
		end else if (channel_reset) begin
			tx_state <= TX_IDLE;
			tx_bits_left <= 4'h0;
			txd <= 1'b1;
		end else if (tx_fall) begin
			case (tx_state)
				TX_IDLE: begin
					if (take_buffer) begin
						txd <= tx_buffer[0];
						tx_shift <= tx_buffer >> 1;
						tx_bits_left <= char_bits(transmit_control[TXC_LEN_LSB +: 2], tx_buffer);
						tx_state <= TX_SHIFT;
					end else begin
						txd <= 1'b1;
					end
				end
				TX_SHIFT: begin
					if (tx_bits_left > 4'h1) begin
						txd <= tx_shift[0];
						tx_shift <= tx_shift >> 1;
						tx_bits_left <= tx_bits_left - 4'h1;
					end else if (take_buffer) begin
						txd <= tx_buffer[0];
						tx_shift <= tx_buffer >> 1;
						tx_bits_left <= char_bits(transmit_control[TXC_LEN_LSB +: 2], tx_buffer);
					end else begin
						txd <= 1'b1;
						tx_bits_left <= 4'h0;
						tx_state <= TX_IDLE;
					end
				end
				default: tx_state <= TX_IDLE;
			endcase
		end
	end

	// underrun: shifter ran dry with nothing in the buffer
	assign underrun_set = tx_fall && tx_state == TX_SHIFT && tx_bits_left == 4'h1 && !take_buffer;

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			underrun_latch <= 1'b1;
		end else if (underrun_set || channel_reset) begin
			underrun_latch <= 1'b1;
		end else if (underrun_reset_cmd) begin
			underrun_latch <= 1'b0;
		end
	end

	// live external/status sources as they read in the status byte
	always_comb begin
		live.break_abort = break_abort;
		live.underrun = underrun_latch;
		live.cts = ~cts_s;
		live.sync_hunt = ~sync_s;
		live.carrier = carrier_s;
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			live_prev <= EXT_STATUS_RESET;
		end else begin
			live_prev <= live;
		end
	end

	// latch on any change; frozen until software resets the interrupt
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			ext_pending <= 1'b0;
			latched <= EXT_STATUS_RESET;
		end else if (live != live_prev && !ext_pending) begin
			ext_pending <= 1'b1;
			latched <= live;
		end else if (live != live_prev && ext_pending) begin
			ext_pending <= 1'b1;
		end else if (ext_reset_cmd || channel_reset) begin
			ext_pending <= 1'b0;
			latched <= live;
		end else if (!ext_pending) begin
			latched <= live;
		end
	end

	assign channel_irq = ext_pending;
	assign int_pending = FIRST_CHANNEL ? (ext_pending || other_channel_irq) : 1'b0;

	// first status register layout
	always_comb begin
		status_byte = 8'h00;
		status_byte[ST_RX_AVAIL] = rx_char_avail;
		status_byte[ST_INT_PENDING] = int_pending;
		status_byte[ST_TX_EMPTY] = tx_buffer_empty;
		status_byte[ST_CARRIER] = latched.carrier;
		status_byte[ST_SYNC_HUNT] = latched.sync_hunt;
		status_byte[ST_CLEAR_TO_SEND] = latched.cts;
		status_byte[ST_UNDERRUN] = latched.underrun;
		status_byte[ST_BREAK] = latched.break_abort;
	end

	// read data registered on the read strobe
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			bus_rdata <= 8'h00;
		end else if (cmd_read) begin
			case (reg_pointer)
				PTR_STATUS: bus_rdata <= status_byte;
				PTR_VECTOR: bus_rdata <= FIRST_CHANNEL ? VECTOR_RESET : 8'h00;
				default: bus_rdata <= 8'h00;
			endcase
		end else if (bus_req.sel && bus_req.rd) begin
			bus_rdata <= 8'h00;
		end
	end

endmodule

// >>> bench/status_monitor.sv
// Purpose: port assertions for the serial channel register slice
// Assumes: register pointer is tracked here from command-side accesses
// Notes: bound to every instance of the slice
`timescale 1ns/1ps
module status_monitor
	import serial_channel_pkg::*;
#(
	parameter bit FIRST_CHANNEL = 1'b1
) (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire bus_req_t bus_req,
	input wire logic [DATA_W-1:0] bus_rdata,
	input wire logic terminal_ready_n,
	input wire logic carrier_detect_n,
	input wire logic rx_char_avail,
	input wire logic [DATA_W-1:0] rx_address,
	input wire logic address_match,
	input wire logic [DATA_W-1:0] tx_sync_char,
	input wire logic [DATA_W-1:0] rx_sync_char,
	input wire logic other_channel_irq,
	input wire logic channel_irq,
	input wire logic int_pending
);
	logic [PTR_W-1:0] ptr;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			ptr <= '0;
		end else if (bus_req.sel && bus_req.cmd && (bus_req.wr || bus_req.rd)) begin
			ptr <= (ptr == PTR_STATUS && bus_req.wr) ? bus_req.wdata[PTR_W-1:0] : PTR_STATUS;
		end
	end
	sequence s_reg_wr(logic [PTR_W-1:0] n);
		bus_req.sel && bus_req.cmd && bus_req.wr && ptr == n;
	endsequence
	sequence s_status_rd;
		bus_req.sel && bus_req.cmd && bus_req.rd && ptr == PTR_STATUS;
	endsequence
	property p_ready;
		s_reg_wr(PTR_TX_CONTROL) |=> terminal_ready_n == !$past(bus_req.wdata[TXC_READY]);
	endproperty
	a_ready: assert property (p_ready) else $error("terminal ready wrong");
	property p_tx_sync;
		s_reg_wr(PTR_TX_SYNC) |=> tx_sync_char == $past(bus_req.wdata);
	endproperty
	a_tx_sync: assert property (p_tx_sync) else $error("transmit sync wrong");
	property p_rx_sync;
		s_reg_wr(PTR_RX_SYNC) |=> rx_sync_char == $past(bus_req.wdata);
	endproperty
	a_rx_sync: assert property (p_rx_sync) else $error("receive sync wrong");
	property p_match;
		$past(arst_n) && $stable(tx_sync_char) |->
			address_match == ($past(rx_address) == tx_sync_char || $past(rx_address) == GLOBAL_ADDRESS);
	endproperty
	a_match: assert property (p_match) else $error("address match wrong");
	property p_avail;
		s_status_rd |=> bus_rdata[ST_RX_AVAIL] == $past(rx_char_avail);
	endproperty
	a_avail: assert property (p_avail) else $error("receive available wrong");
	property p_pend_set;
		(FIRST_CHANNEL && (channel_irq || other_channel_irq))[*3] |-> int_pending;
	endproperty
	a_pend_set: assert property (p_pend_set) else $error("pending not set");
	property p_pend_clr;
		(!channel_irq && !other_channel_irq)[*3] |-> !int_pending;
	endproperty
	a_pend_clr: assert property (p_pend_clr) else $error("pending not cleared");
	property p_ext;
		$changed(carrier_detect_n) && !channel_irq |-> ##[1:6] channel_irq;
	endproperty
	a_ext: assert property (p_ext) else $error("carrier change not flagged");
endmodule
bind serial_channel_sync_regs_status status_monitor #(.FIRST_CHANNEL(FIRST_CHANNEL)) i_status_monitor (
	.ref_clk(ref_clk),
	.arst_n(arst_n),
	.bus_req(bus_req),
	.bus_rdata(bus_rdata),
	.terminal_ready_n(terminal_ready_n),
	.carrier_detect_n(carrier_detect_n),
	.rx_char_avail(rx_char_avail),
	.rx_address(rx_address),
	.address_match(address_match),
	.tx_sync_char(tx_sync_char),
	.rx_sync_char(rx_sync_char),
	.other_channel_irq(other_channel_irq),
	.channel_irq(channel_irq),
	.int_pending(int_pending)
);

// >>> bench/link_partner.sv
// Purpose: far end of the transmit line
// Assumes: clock idles high between frames
// Notes: samples each bit on the rising clock edge
`timescale 1ns/1ps
module link_partner (
	output logic tx_clk,
	input wire logic txd
);
	initial tx_clk = 1'b1;
	task automatic run_frame(input int n, output logic [15:0] bits);
		bits = '0;
		for (int i = 0; i < n; i++) begin
			#80 tx_clk = 1'b0;
			#80 tx_clk = 1'b1;
			bits[i] = txd;
		end
	endtask
endmodule

// >>> bench/tb.sv
// Purpose: self-checking bench for the serial channel register slice
// Assumes: first channel instance, register access by pointer
// Notes: transmit clock made by the link partner only inside frames
`timescale 1ns/1ps
module tb;
	import serial_channel_pkg::*;
	logic ref_clk, arst_n, txd, terminal_ready_n, tx_clk, address_match, channel_irq, int_pending;
	logic carrier_detect_n, clear_to_send_n, rx_char_avail, crc_sending, sync_mode, other_channel_irq;
	bus_req_t bus_req;
	logic [DATA_W-1:0] bus_rdata, rx_address, tx_sync_char, rx_sync_char, d, v;
	logic [15:0] got;
	int n, n_fail, n_compared;
	serial_channel_sync_regs_status #(.FIRST_CHANNEL(1'b1)) i_serial_channel_sync_regs_status (
		.ref_clk(ref_clk), .arst_n(arst_n), .bus_req(bus_req), .bus_rdata(bus_rdata), .tx_clk(tx_clk),
		.txd(txd), .terminal_ready_n(terminal_ready_n), .carrier_detect_n(carrier_detect_n),
		.clear_to_send_n(clear_to_send_n), .sync_n(1'b1), .rx_char_avail(rx_char_avail),
		.break_abort(1'b0), .crc_sending(crc_sending), .sync_mode(sync_mode), .rx_address(rx_address),
		.address_match(address_match), .tx_sync_char(tx_sync_char), .rx_sync_char(rx_sync_char),
		.other_channel_irq(other_channel_irq), .channel_irq(channel_irq), .int_pending(int_pending));
	link_partner i_link_partner (.tx_clk(tx_clk), .txd(txd));
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic access(input logic c, input logic w, input logic [7:0] wd);
		@(posedge ref_clk);
		bus_req <= '{sel: 1'b1, cmd: c, wr: w, rd: !w, wdata: wd};
		@(posedge ref_clk);
		bus_req <= '0;
		#1 d = bus_rdata;
	endtask
	task automatic wreg(input logic [2:0] p, input logic [7:0] val);
		access(1'b1, 1'b1, {5'h00, p});
		access(1'b1, 1'b1, val);
	endtask
	task automatic status(input logic [7:0] mask, input logic [7:0] exp);
		access(1'b1, 1'b0, 8'h00);
		chk("status", d & mask, exp);
	endtask
	task automatic pins(input logic cd_n, input logic cts_n, input logic oth, input logic avail);
		@(posedge ref_clk);
		carrier_detect_n <= cd_n;
		clear_to_send_n <= cts_n;
		other_channel_irq <= oth;
		rx_char_avail <= avail;
		repeat (6) @(posedge ref_clk);
	endtask
	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		#200000;
		n_fail++;
		finish_test;
	end
	initial begin
		arst_n = 1'b0;
		bus_req = '0;
		carrier_detect_n = 1'b1;
		clear_to_send_n = 1'b1;
		rx_char_avail = 1'b0;
		crc_sending = 1'b0;
		sync_mode = 1'b0;
		other_channel_irq = 1'b0;
		rx_address = 8'h00;
		repeat (4) @(posedge ref_clk);
		arst_n <= 1'b1;
		repeat (3) @(posedge ref_clk);
		chk("ready", terminal_ready_n, 16'h1);
		status(8'h44, 8'h44);
		wreg(PTR_TX_SYNC, 8'h3C);
		chk("tx sync", tx_sync_char, 16'h3C);
		wreg(PTR_RX_SYNC, 8'h7E);
		chk("rx sync", rx_sync_char, 16'h7E);
		@(posedge ref_clk) rx_address <= 8'h3C;
		repeat (3) @(posedge ref_clk);
		chk("match", address_match, 16'h1);
		@(posedge ref_clk) rx_address <= 8'h3D;
		repeat (3) @(posedge ref_clk);
		chk("match", address_match, 16'h0);
		@(posedge ref_clk) rx_address <= 8'hFF;
		repeat (3) @(posedge ref_clk);
		chk("global match", address_match, 16'h1);
		access(1'b1, 1'b1, {5'h00, PTR_VECTOR});
		access(1'b1, 1'b0, 8'h00);
		chk("vector", d, 16'h0);
		access(1'b0, 1'b0, 8'h00);
		chk("data read", d, 16'h0);
		pins(1'b1, 1'b1, 1'b0, 1'b1);
		status(8'h01, 8'h01);
		pins(1'b1, 1'b1, 1'b0, 1'b0);
		status(8'h01, 8'h00);
		access(1'b1, 1'b1, {2'h0, CMD_RESET_EXT, 3'h0});
		pins(1'b1, 1'b1, 1'b1, 1'b0);
		status(8'h02, 8'h02);
		pins(1'b1, 1'b1, 1'b0, 1'b0);
		status(8'h02, 8'h00);
		pins(1'b0, 1'b0, 1'b0, 1'b0);
		chk("irq", channel_irq, 16'h1);
		status(8'h3A, 8'h22);
		pins(1'b1, 1'b1, 1'b0, 1'b0);
		status(8'h28, 8'h20);
		access(1'b1, 1'b1, {2'h0, CMD_RESET_EXT, 3'h0});
		status(8'h28, 8'h08);
		for (int c = 0; c < 4; c++) begin
			n = (c == 0) ? 2 : (c == 1) ? 7 : (c == 2) ? 6 : 8;
			// ones, zero marker, then two data bits
			v = (c == 0) ? 8'hE2 : 8'h25;
			wreg(PTR_TX_CONTROL, {1'b1, c[1:0], 5'h08});
			chk("ready", terminal_ready_n, 16'h0);
			access(1'b0, 1'b1, v);
			status(8'h04, 8'h00);
			i_link_partner.run_frame(n + 1, got);
			chk("txd bits", got, (16'h1 << n) | ({8'h00, v} & ((16'h1 << n) - 16'h1)));
			status(8'h04, 8'h04);
		end
		@(posedge ref_clk);
		sync_mode <= 1'b1;
		crc_sending <= 1'b1;
		access(1'b0, 1'b1, 8'h25);
		i_link_partner.run_frame(9, got);
		status(8'h04, 8'h00);
		@(posedge ref_clk);
		sync_mode <= 1'b0;
		crc_sending <= 1'b0;
		// reset-underrun command clears the latch and the change is snapshot
		access(1'b1, 1'b1, 8'hC0);
		status(8'h42, 8'h02);
		access(1'b1, 1'b1, {2'h0, CMD_CHANNEL_RESET, 3'h0});
		chk("ready", terminal_ready_n, 16'h1);
		status(8'h44, 8'h44);
		finish_test;
	end
endmodule
